// ---- hw/osel_top.sv ----
// module: oscillator source select, pin reuse and internal oscillator control
`default_nettype none
module osel_top
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [2:0] clock_mode_cfg,
  input wire logic two_speed_startup_enable,
  input wire osel_pkg::osel_ctrl_t ctrl,
  input wire logic fast_osc_ready_pin,
  input wire logic slow_osc_ready_pin,
  input wire logic slow_osc_keep_alive,
  input wire osel_pkg::osel_pin_t gpio_in_pin_drive,
  input wire osel_pkg::osel_pin_t gpio_out_pin_drive,
  output logic [1:0] amp_gain,
  output logic amp_feedback_en,
  output logic [1:0] sys_clock_source,
  output logic [2:0] internal_freq_select,
  output logic [2:0] postscale_shift,
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic fast_osc_stable_flag,
  output logic slow_osc_stable_flag,
  output logic signed [4:0] fast_osc_trim_value,
  output logic trim_shift_start,
  output osel_pkg::osel_pin_t oscillator_input_pin,
  output osel_pkg::osel_pin_t oscillator_output_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0] mode_reg; // registered clock mode configuration
  logic two_speed_startup_enable_reg; // registered two-speed start-up enable
  logic scs_reg; // system clock source select
  logic [2:0] freq_reg; // frequency select state
  logic [4:0] trim_reg; // trim state
  logic fast_sync1_reg; // first synchroniser stage, fast ready
  logic fast_sync2_reg; // second synchroniser stage, fast ready
  logic slow_sync1_reg; // first synchroniser stage, slow ready
  logic slow_sync2_reg; // second synchroniser stage, slow ready
  logic div4; // divide-by-four square wave
  logic int_mode; // configured for an internal oscillator mode
  logic use_internal; // internal oscillators clock the core
  logic fast_en_next; // fast oscillator enable term
  logic slow_en_next; // slow oscillator enable term
  logic [1:0] gain_next; // amplifier gain for the mode
  logic [1:0] src_next; // system clock source for the mode
  osel_pkg::osel_pin_t in_pin_next; // first pin drive
  osel_pkg::osel_pin_t out_pin_next; // second pin drive

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // decode the configuration field into amplifier gain
  function automatic logic [1:0] gain_of(input logic [2:0] mode);
    case (mode)
      osel_pkg::MODE_LOW_GAIN_XTAL: gain_of = osel_pkg::GAIN_LOW;
      osel_pkg::MODE_MED_GAIN_XTAL: gain_of = osel_pkg::GAIN_MED;
      osel_pkg::MODE_HIGH_GAIN_XTAL: gain_of = osel_pkg::GAIN_HIGH;
      default: gain_of = osel_pkg::GAIN_OFF;
    endcase
  endfunction

  // true for the two internal oscillator modes
  function automatic logic is_int_mode(input logic [2:0] mode);
    is_int_mode = (mode == osel_pkg::MODE_INT_PIN_IO) || (mode == osel_pkg::MODE_INT_CLOCK_OUT_PIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // divide-by-four clock source for the clock-out pin
  osel_div4 u_div4
  (
    .clk (clk),
    .reset (reset),
    .clk_en (clk_en),
    .div4 (div4)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration capture, same clock domain, so no synchroniser
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_reg <= clock_mode_cfg;
      two_speed_startup_enable_reg <= two_speed_startup_enable;
    end
    else if (clk_en)
    begin
      mode_reg <= clock_mode_cfg;
      two_speed_startup_enable_reg <= two_speed_startup_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control: source select and frequency select
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scs_reg <= 1'b0;
      freq_reg <= osel_pkg::FREQ_SEL_RESET;
    end
    else if (clk_en)
    begin
      scs_reg <= ctrl.system_clock_source_select;
      if (ctrl.freq_wr)
        freq_reg <= ctrl.freq_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trim register and shift-start pulse; the shift itself is analog
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trim_reg <= osel_pkg::TRIM_RESET;
      trim_shift_start <= 1'b0;
    end
    else if (clk_en)
    begin
      trim_shift_start <= ctrl.trim_wr;
      if (ctrl.trim_wr)
        trim_reg <= ctrl.trim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready levels from the analog oscillators cross in through two flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fast_sync1_reg <= 1'b0;
      fast_sync2_reg <= 1'b0;
      slow_sync1_reg <= 1'b0;
      slow_sync2_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_sync1_reg <= fast_osc_ready_pin;
      fast_sync2_reg <= fast_sync1_reg;
      slow_sync1_reg <= slow_osc_ready_pin;
      slow_sync2_reg <= slow_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: source, enables, gain and pin reuse
  always_comb
  begin
    int_mode = is_int_mode(mode_reg);
    use_internal = scs_reg || int_mode;
    fast_en_next = (freq_reg != osel_pkg::FREQ_SEL_SLOW) && (use_internal || two_speed_startup_enable_reg);
    // slow oscillator has its own enable and never sees the trim
    slow_en_next = ((freq_reg == osel_pkg::FREQ_SEL_SLOW) && (use_internal || two_speed_startup_enable_reg))
      || slow_osc_keep_alive;
    gain_next = gain_of(mode_reg);
    // source: internal when selected by software or by the mode
    if (use_internal)
      src_next = (freq_reg == osel_pkg::FREQ_SEL_SLOW) ? osel_pkg::SRC_SLOW_INT : osel_pkg::SRC_FAST_INT;
    else if ((mode_reg == osel_pkg::MODE_RC_PIN_IO) || (mode_reg == osel_pkg::MODE_RC_CLOCK_OUT_PIN))
      src_next = osel_pkg::SRC_CFG_RC;
    else
      src_next = osel_pkg::SRC_CFG_EXTERNAL;
    // pins default to released: analog crystal or rc network
    in_pin_next = '0;
    out_pin_next = '0;
    case (mode_reg)
      osel_pkg::MODE_RC_CLOCK_OUT_PIN:
      begin
        out_pin_next.out = div4;
        out_pin_next.oe = 1'b1;
      end
      osel_pkg::MODE_RC_PIN_IO, osel_pkg::MODE_EXT_CLOCK:
      begin
        out_pin_next = gpio_out_pin_drive;
      end
      osel_pkg::MODE_INT_CLOCK_OUT_PIN:
      begin
        in_pin_next = gpio_in_pin_drive;
        out_pin_next.out = div4;
        out_pin_next.oe = 1'b1;
      end
      osel_pkg::MODE_INT_PIN_IO:
      begin
        in_pin_next = gpio_in_pin_drive;
        out_pin_next = gpio_out_pin_drive;
      end
      default:
      begin
        in_pin_next = '0; // crystal pins belong to the amplifier
        out_pin_next = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: clock source control
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      amp_gain <= osel_pkg::GAIN_OFF;
      amp_feedback_en <= 1'b0;
      sys_clock_source <= osel_pkg::SRC_CFG_EXTERNAL;
      internal_freq_select <= osel_pkg::FREQ_SEL_RESET;
      postscale_shift <= 3'h1;
      fast_osc_enable <= 1'b0;
      slow_osc_enable <= 1'b0;
      fast_osc_trim_value <= osel_pkg::TRIM_RESET;
    end
    else if (clk_en)
    begin
      amp_gain <= gain_next;
      amp_feedback_en <= (gain_next != osel_pkg::GAIN_OFF);
      sys_clock_source <= src_next;
      internal_freq_select <= freq_reg;
      // postscaler divides 8 MHz by 2^(7-code); unused for the slow code
      postscale_shift <= osel_pkg::FREQ_SEL_MAX - freq_reg;
      fast_osc_enable <= fast_en_next;
      slow_osc_enable <= slow_en_next;
      fast_osc_trim_value <= $signed(trim_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: status flags and pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fast_osc_stable_flag <= 1'b0;
      slow_osc_stable_flag <= 1'b0;
      oscillator_input_pin <= '0;
      oscillator_output_pin <= '0;
    end
    else if (clk_en)
    begin
      fast_osc_stable_flag <= fast_sync2_reg && fast_osc_enable;
      slow_osc_stable_flag <= slow_sync2_reg && slow_osc_enable;
      oscillator_input_pin <= in_pin_next;
      oscillator_output_pin <= out_pin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_gain;
    clk_en && (mode_reg == osel_pkg::MODE_HIGH_GAIN_XTAL) |=> (amp_gain == osel_pkg::GAIN_HIGH);
  endproperty
  a_gain: assert property (p_gain) else $error("high gain mode without high gain");

  property p_rc_clock_out_pin;
    clk_en && (mode_reg == osel_pkg::MODE_RC_CLOCK_OUT_PIN) |=> oscillator_output_pin.oe
      && (oscillator_output_pin.out == $past(div4));
  endproperty
  a_rc_clock_out_pin: assert property (p_rc_clock_out_pin) else $error("rc clock out not driven");

  property p_rc_io;
    clk_en && (mode_reg == osel_pkg::MODE_RC_PIN_IO) |=> (oscillator_output_pin == $past(gpio_out_pin_drive));
  endproperty
  a_rc_io: assert property (p_rc_io) else $error("rc io pin not released");

  property p_int_clock_out_pin;
    clk_en && (mode_reg == osel_pkg::MODE_INT_CLOCK_OUT_PIN) |=> oscillator_output_pin.oe
      && (oscillator_input_pin == $past(gpio_in_pin_drive));
  endproperty
  a_int_clock_out_pin: assert property (p_int_clock_out_pin) else $error("internal clock_out_pin pins wrong");

  property p_int_io;
    clk_en && (mode_reg == osel_pkg::MODE_INT_PIN_IO) |=> (oscillator_output_pin == $past(gpio_out_pin_drive));
  endproperty
  a_int_io: assert property (p_int_io) else $error("internal io pin not released");

  property p_fast_en;
    clk_en |=> (fast_osc_enable == (($past(freq_reg) != 3'h0) && ($past(use_internal) || $past(two_speed_startup_enable_reg))));
  endproperty
  a_fast_en: assert property (p_fast_en) else $error("fast oscillator enable wrong");

  property p_stable;
    fast_osc_stable_flag |-> $past(fast_osc_enable);
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag while disabled");

  property p_trim_pulse;
    clk_en && ctrl.trim_wr ##1 clk_en |=> (fast_osc_trim_value == $past(ctrl.trim, 2))
      && (trim_shift_start == $past(ctrl.trim_wr));
  endproperty
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim not applied");

  property p_src_sel;
    clk_en && scs_reg && (freq_reg == 3'h0) |=> (sys_clock_source == osel_pkg::SRC_SLOW_INT);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("slow source not selected");

  c_rc_clock_out_pin: cover property (clk_en && mode_reg == osel_pkg::MODE_RC_CLOCK_OUT_PIN ##1 oscillator_output_pin.out);
  c_trim: cover property (trim_shift_start);
  c_stable: cover property (fast_osc_stable_flag);
  c_slow: cover property (sys_clock_source == osel_pkg::SRC_SLOW_INT);

endmodule // osel_top
`default_nettype wire

// ---- include/osel_pkg.sv ----
// package: constants, modes and carrier types for the oscillator source select block
`default_nettype none
package osel_pkg;

  // clock mode configuration field codes (programming-time strap)
  localparam logic [2:0] MODE_LOW_GAIN_XTAL = 3'h0; // low_gain_crystal_mode
  localparam logic [2:0] MODE_MED_GAIN_XTAL = 3'h1; // medium_gain_crystal_mode
  localparam logic [2:0] MODE_HIGH_GAIN_XTAL = 3'h2; // high_gain_crystal_mode
  localparam logic [2:0] MODE_EXT_CLOCK = 3'h3; // external logic clock, second pin is io
  localparam logic [2:0] MODE_INT_PIN_IO = 3'h4; // internal_osc_both_pins_io_mode
  localparam logic [2:0] MODE_INT_CLOCK_OUT_PIN = 3'h5; // internal_osc_clock_out_mode
  localparam logic [2:0] MODE_RC_PIN_IO = 3'h6; // resistor_capacitor_pin_io_mode
  localparam logic [2:0] MODE_RC_CLOCK_OUT_PIN = 3'h7; // resistor_capacitor_clock_out_pin_mode

  // amplifier gain codes
  localparam logic [1:0] GAIN_OFF = 2'h0; // amplifier disabled
  localparam logic [1:0] GAIN_LOW = 2'h1; // watch crystal drive
  localparam logic [1:0] GAIN_MED = 2'h2; // medium drive
  localparam logic [1:0] GAIN_HIGH = 2'h3; // high drive

  // system clock source codes
  localparam logic [1:0] SRC_CFG_EXTERNAL = 2'h0; // crystal or external logic clock
  localparam logic [1:0] SRC_CFG_RC = 2'h1; // external rc network
  localparam logic [1:0] SRC_FAST_INT = 2'h2; // postscaled fast internal oscillator
  localparam logic [1:0] SRC_SLOW_INT = 2'h3; // slow internal oscillator

  // frequency select codes and reset values
  localparam logic [2:0] FREQ_SEL_SLOW = 3'h0; // 31 kHz slow oscillator
  localparam logic [2:0] FREQ_SEL_MAX = 3'h7; // 8 MHz, undivided
  localparam logic [2:0] FREQ_SEL_RESET = 3'h6; // 4 MHz after reset
  localparam logic [4:0] TRIM_RESET = 5'h00; // factory calibrated frequency
  localparam logic [4:0] TRIM_MAX = 5'h0F; // highest frequency
  localparam logic [4:0] TRIM_MIN = 5'h10; // lowest frequency
  localparam logic [1:0] DIV4_RESET = 2'h0; // clock-out counter start

  // nominal frequencies in kHz
  localparam int FAST_OSC_KHZ = 8000;
  localparam int SLOW_OSC_KHZ = 31;

  // one oscillator pin seen from the core: drive value and enable
  typedef struct packed {
    logic out; // level driven onto the pin
    logic oe; // high while the block drives the pin
  } osel_pin_t;

  // software control carried to the block
  typedef struct packed {
    logic [2:0] freq_sel; // internal_freq_select value
    logic freq_wr; // one-cycle write strobe for freq_sel
    logic [4:0] trim; // fast_osc_trim_value, signed
    logic trim_wr; // one-cycle write strobe for trim
    logic system_clock_source_select; // system_clock_source_select
  } osel_ctrl_t;

endpackage : osel_pkg
`default_nettype wire

// ---- hw/osel_div4.sv ----
// module: free-running divide-by-four counter for the clock-out pin
`default_nettype none
module osel_div4
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  output logic div4
);

  logic [1:0] count_reg; // two-bit phase counter

  ////////////////////////////////////////////////////////////////////////////
  // counter runs on every enabled edge, top bit is a 50 percent square wave
  always_ff @(posedge clk)
  begin
    if (reset)
      count_reg <= osel_pkg::DIV4_RESET;
    else if (clk_en)
      count_reg <= count_reg + 2'h1;
  end

  assign div4 = count_reg[1];

endmodule // osel_div4
`default_nettype wire

// ---- dv/osel_osc_model.sv ----
// partner model: fast and slow internal oscillators reporting readiness
`default_nettype none
module osel_osc_model
#(
  parameter int FAST_CYCLES = 8, // fast oscillator start-up, in clocks
  parameter int SLOW_CYCLES = 2 // slow oscillator start-up, in clocks
)
(
  input wire logic clk,
  input wire logic fast_en,
  input wire logic slow_en,
  output logic fast_ready,
  output logic slow_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int fast_cnt = 0; // cycles since fast enable
  int slow_cnt = 0; // cycles since slow enable
  initial fast_ready = 1'b0;
  initial slow_ready = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // fast oscillator: ready after start-up, drops at once when disabled
  always @(posedge clk)
  begin
    fast_cnt <= fast_en ? fast_cnt + 1 : 0;
    fast_ready <= fast_en && (fast_cnt >= FAST_CYCLES);
  end
  ////////////////////////////////////////////////////////////////////////////
  // slow oscillator: own enable, no trim input at all
  always @(posedge clk)
  begin
    slow_cnt <= slow_en ? slow_cnt + 1 : 0;
    slow_ready <= slow_en && (slow_cnt >= SLOW_CYCLES);
  end
endmodule // osel_osc_model
`default_nettype wire

// ---- dv/oscillator_source_select_tb_top.sv ----
// testbench: scenario tasks for the oscillator source select block
`default_nettype none
module oscillator_source_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk; // system clock
  logic reset; // synchronous reset
  logic clk_en; // clock enable, low freezes the block
  logic [2:0] mode; // clock mode strap
  logic two_speed; // two-speed start-up strap
  logic keep_alive; // keeps slow oscillator running
  osel_pkg::osel_ctrl_t ctrl; // software control
  osel_pkg::osel_pin_t gin; // port drive for first pin
  osel_pkg::osel_pin_t gout; // port drive for second pin
  logic fast_rdy;
  logic slow_rdy;
  logic [1:0] gain;
  logic fb;
  logic [1:0] src;
  logic [2:0] fsel;
  logic [2:0] shift;
  logic fen;
  logic sen;
  logic fflag;
  logic sflag;
  logic signed [4:0] trim;
  logic tpulse;
  osel_pkg::osel_pin_t pin1;
  osel_pkg::osel_pin_t pin2;
  int fail_count = 0; // mismatches seen
  int total_checks = 0; // comparisons made
  ////////////////////////////////////////////////////////////////////////////
  // design and oscillator model
  osel_top i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .clock_mode_cfg(mode),
    .two_speed_startup_enable(two_speed), .ctrl(ctrl), .fast_osc_ready_pin(fast_rdy),
    .slow_osc_ready_pin(slow_rdy), .slow_osc_keep_alive(keep_alive), .gpio_in_pin_drive(gin),
    .gpio_out_pin_drive(gout), .amp_gain(gain), .amp_feedback_en(fb), .sys_clock_source(src),
    .internal_freq_select(fsel), .postscale_shift(shift), .fast_osc_enable(fen),
    .slow_osc_enable(sen), .fast_osc_stable_flag(fflag), .slow_osc_stable_flag(sflag),
    .fast_osc_trim_value(trim), .trim_shift_start(tpulse), .oscillator_input_pin(pin1),
    .oscillator_output_pin(pin2));
  osel_osc_model #(.FAST_CYCLES(8), .SLOW_CYCLES(2)) i_osc (.clk(clk), .fast_en(fen),
    .slow_en(sen), .fast_ready(fast_rdy), .slow_ready(slow_rdy));
  ////////////////////////////////////////////////////////////////////////////
  // clock generation
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare tasks: plain values and pin structs
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_pin(input osel_pkg::osel_pin_t got, input osel_pkg::osel_pin_t exp, input string what);
    chk_val({6'h00, got}, {6'h00, exp}, what);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // drivers: straps and control strobes, then let outputs settle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic set_mode(input logic [2:0] m, input logic s);
    @(posedge clk);
    mode <= m;
    ctrl.system_clock_source_select <= s;
    settle();
  endtask
  task automatic wr_freq(input logic [2:0] c);
    @(posedge clk);
    ctrl.freq_sel <= c;
    ctrl.freq_wr <= 1'b1;
    @(posedge clk);
    ctrl.freq_wr <= 1'b0;
    settle();
  endtask
  // clock-out toggles every two cycles while driven
  task automatic chk_div();
    logic s [8];
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      s[i] = pin2.out;
      chk_val({7'h00, pin2.oe}, 8'h01, "clock_out_pin enable");
    end
    for (int i = 0; i < 6; i++)
      chk_val({7'h00, s[i + 2]}, (s[i] === 1'b1) ? 8'h00 : 8'h01, "clock_out_pin /4");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk_val({5'h00, fsel}, {5'h00, osel_pkg::FREQ_SEL_RESET}, "reset select");
    chk_val({3'h0, trim}, {3'h0, osel_pkg::TRIM_RESET}, "reset trim");
    chk_val({6'h00, tpulse, fflag}, 8'h00, "reset pulse and flag");
    $display("test reset done");
  endtask
  task automatic t_gain();
    for (int i = 0; i < 3; i++)
    begin
      set_mode(i[2:0], 1'b0);
      chk_val({6'h00, gain}, 8'(i + 1), "crystal gain");
      chk_val({6'h00, fb, pin2.oe}, 8'h02, "feedback and pin2 released");
      chk_val({6'h00, src}, {6'h00, osel_pkg::SRC_CFG_EXTERNAL}, "configured source");
    end
    $display("test gain done");
  endtask
  task automatic t_pins();
    set_mode(osel_pkg::MODE_RC_PIN_IO, 1'b0);
    chk_pin(pin2, gout, "rc io second pin");
    chk_val({7'h00, pin1.oe}, 8'h00, "rc first pin input");
    chk_val({6'h00, src}, {6'h00, osel_pkg::SRC_CFG_RC}, "rc source");
    set_mode(osel_pkg::MODE_RC_CLOCK_OUT_PIN, 1'b0);
    chk_val({7'h00, pin1.oe}, 8'h00, "rc clock_out_pin first pin");
    chk_div();
    set_mode(osel_pkg::MODE_INT_PIN_IO, 1'b0);
    chk_pin(pin1, gin, "int io first pin");
    chk_pin(pin2, gout, "int io second pin");
    chk_val({6'h00, src}, {6'h00, osel_pkg::SRC_FAST_INT}, "internal mode source");
    set_mode(osel_pkg::MODE_INT_CLOCK_OUT_PIN, 1'b0);
    chk_pin(pin1, gin, "int clock_out_pin first pin");
    chk_div();
    set_mode(osel_pkg::MODE_EXT_CLOCK, 1'b0);
    chk_pin(pin2, gout, "ext clock second pin");
    chk_val({6'h00, src}, {6'h00, osel_pkg::SRC_CFG_EXTERNAL}, "ext clock source");
    chk_val({5'h00, gain, fb}, 8'h00, "ext clock amplifier off");
    $display("test pins done");
  endtask
  task automatic t_freq();
    set_mode(osel_pkg::MODE_HIGH_GAIN_XTAL, 1'b1);
    for (int c = 7; c >= 0; c--)
    begin
      wr_freq(c[2:0]);
      chk_val({5'h00, fsel}, 8'(c), "select readback");
      chk_val({7'h00, fen}, (c != 0) ? 8'h01 : 8'h00, "fast enable");
      chk_val({6'h00, src}, (c != 0) ? 8'h02 : 8'h03, "internal source");
      if (c != 0)
        chk_val({5'h00, shift}, 8'(7 - c), "postscale");
    end
    wr_freq(3'h6);
    set_mode(osel_pkg::MODE_HIGH_GAIN_XTAL, 1'b0);
    chk_val({6'h00, fen, src[1]}, 8'h00, "fast off when external");
    @(posedge clk);
    two_speed <= 1'b1;
    settle();
    chk_val({7'h00, fen}, 8'h01, "fast on by two-speed");
    @(posedge clk);
    two_speed <= 1'b0;
    settle();
    $display("test freq done");
  endtask
  task automatic t_stable();
    set_mode(osel_pkg::MODE_HIGH_GAIN_XTAL, 1'b1);
    chk_val({6'h00, fen, fflag}, 8'h02, "flag low while starting");
    for (int n = 0; n < 30 && fflag !== 1'b1; n++)
      @(negedge clk);
    chk_val({7'h00, fflag}, 8'h01, "flag high when stable");
    wr_freq(3'h0);
    settle();
    chk_val({6'h00, fflag, sflag}, 8'h01, "fast flag drops, slow holds");
    $display("test stable done");
  endtask
  task automatic t_trim();
    logic [4:0] tv [4] = '{osel_pkg::TRIM_MAX, osel_pkg::TRIM_MIN, 5'h1F, 5'h00};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ctrl.trim <= tv[i];
      ctrl.trim_wr <= 1'b1;
      @(posedge clk);
      ctrl.trim_wr <= 1'b0;
      @(negedge clk);
      chk_val({7'h00, tpulse}, 8'h01, "shift start");
      @(negedge clk);
      chk_val({7'h00, tpulse}, 8'h00, "shift start ends");
      chk_val({3'h0, trim}, {3'h0, tv[i]}, "trim value");
      chk_val({6'h00, sen, sflag}, 8'h03, "slow unaffected");
    end
    $display("test trim done");
  endtask
  // a strobe while the enable is low must be ignored
  task automatic t_hold();
    @(posedge clk);
    clk_en <= 1'b0;
    ctrl.trim <= 5'h05;
    ctrl.trim_wr <= 1'b1;
    @(posedge clk);
    ctrl.trim_wr <= 1'b0;
    settle();
    chk_val({7'h00, tpulse}, 8'h00, "frozen shift start");
    chk_val({3'h0, trim}, 8'h00, "frozen trim");
    @(posedge clk);
    clk_en <= 1'b1;
    settle();
    chk_val({3'h0, trim}, 8'h00, "trim after freeze");
    $display("test hold done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // closing: counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    mode = osel_pkg::MODE_LOW_GAIN_XTAL;
    two_speed = 1'b0;
    keep_alive = 1'b1;
    ctrl = '0;
    ctrl.freq_sel = osel_pkg::FREQ_SEL_RESET;
    gin = '{out: 1'b1, oe: 1'b1};
    gout = '{out: 1'b0, oe: 1'b1};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_gain();
    t_pins();
    t_freq();
    t_stable();
    t_trim();
    t_hold();
    results();
  end
endmodule // oscillator_source_select_tb_top
`default_nettype wire
